// File: pfa_defs.svh
// timing-free constants for the program flow and indirect addressing block
// assumes inclusion by bare name from the design file
`ifndef PFA_DEFS_SVH
`define PFA_DEFS_SVH
`define PFA_PC_W 13
`define PFA_PAGE_W 11
`define PFA_STACK_DEPTH 8
`define PFA_SP_W 3
`define PFA_RESET_PC 13'h0000
`define PFA_INT_VECTOR 13'h0004
`define PFA_INDIRECT_DATA_PORT_ADDR 7'h00
`define PFA_PCL_ADDR 7'h02
`define PFA_FSR_ADDR 7'h04
`define PFA_INDIRECT_DATA_PORT_READ 8'h00
`endif

// File: pfa_pkg.sv
// types for the program flow and indirect addressing block
// assumes nothing beyond a SystemVerilog compiler
package pfa_pkg;
  typedef enum logic [4:0] {
    PFA_OP_NEXT = 5'h01,
    PFA_OP_JUMP = 5'h02,
    PFA_OP_CALL = 5'h04,
    PFA_OP_RET = 5'h08,
    PFA_OP_INTR = 5'h10
  } pfa_op_t;
endpackage

// File: pfa_core.sv
// program counter, return stack and indirect address generation
// assumes the decoder presents one op per clock and the data bus maps files by address
// How it works
// - 13-bit counter; low byte is a data-space file that reads and writes
// - upper five bits never written directly; loaded from the latch, target, stack or vector, or by carry
// - reset clears the whole counter to zero
// - a low-byte write loads upper bits from latch bits 4..0 together
// - call or jump gives 11 bits, latch bits 4..3 give the page
// - page plus in-page address reaches one continuous 8K-word space
// - adding to the low byte is a computed branch with latch upper bits
// - eight 13-bit return entries, pointer hidden from software
// - call or interrupt branch pushes the return address
// - return, return with literal, return from interrupt pop the full counter
// - push and pop never touch the upper latch
// - stack is circular, ninth push overwrites the first entry
// - no overflow or underflow flag exists
// - access to the indirect port goes to the pointed-to location
// - indirect read of the indirect port itself returns zero
// - indirect write of the indirect port itself stores nothing
// - effective address is bank bit above the 8-bit pointer
// - interrupt branch loads the fixed vector after pushing
`include "pfa_defs.svh"

module pfa_core #(
  parameter int DEPTH = `PFA_STACK_DEPTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // decoder
  input wire pfa_pkg::pfa_op_t i_op,
  input wire logic [`PFA_PAGE_W-1:0] i_target,
  input wire logic i_file_wr,
  input wire logic [6:0] i_file_addr,
  input wire logic [7:0] i_file_wdata,
  input wire logic [7:0] i_pc_upper_latch,
  input wire logic i_indirect_bank_bit,
  // data memory
  input wire logic [7:0] i_mem_rdata,
  output logic [8:0] o_mem_addr,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  // results
  output logic [`PFA_PC_W-1:0] o_pc,
  output logic [7:0] o_pc_low_byte_reg,
  output logic [7:0] o_indirect_pointer_reg,
  output logic [7:0] o_file_rdata
);

  localparam int SPW = $clog2(DEPTH);

  logic [`PFA_PC_W-1:0] pc_q;
  logic [`PFA_PC_W-1:0] pc_d;
  logic [`PFA_PC_W-1:0] stack_q [DEPTH];
  logic [SPW-1:0] sp_q;
  logic [7:0] fsr_q;
  logic pcl_wr;
  logic [8:0] eff_addr;
  logic self_ref;
  logic is_indirect_data_port;

  function automatic logic [`PFA_PC_W-1:0] pc_plus1(input logic [`PFA_PC_W-1:0] pc);
    pc_plus1 = pc + 13'h0001;
  endfunction

  assign pcl_wr = i_file_wr && (i_file_addr == `PFA_PCL_ADDR);
  assign is_indirect_data_port = i_file_addr == `PFA_INDIRECT_DATA_PORT_ADDR;

  //----------------------------------------
  // program counter
  //----------------------------------------
  // pcl write (incl. computed add) has priority over sequencing; stack never touches latch
  always_comb begin
    pc_d = pc_plus1(pc_q);
    if (pcl_wr) begin
      pc_d = {i_pc_upper_latch[4:0], i_file_wdata};
    end else begin
      unique case (i_op)
        pfa_pkg::PFA_OP_NEXT: pc_d = pc_plus1(pc_q);
        pfa_pkg::PFA_OP_JUMP,
        pfa_pkg::PFA_OP_CALL: pc_d = {i_pc_upper_latch[4:3], i_target};
        pfa_pkg::PFA_OP_RET: pc_d = stack_q[sp_q - 1'b1];
        pfa_pkg::PFA_OP_INTR: pc_d = `PFA_INT_VECTOR;
        default: pc_d = pc_plus1(pc_q);
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pc_q <= `PFA_RESET_PC;
    end else begin
      pc_q <= pc_d;
    end
  end

  //----------------------------------------
  // return stack
  //----------------------------------------
  // no flags: wrap silently in both directions
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sp_q <= '0;
    end else if (!pcl_wr && (i_op == pfa_pkg::PFA_OP_CALL || i_op == pfa_pkg::PFA_OP_INTR)) begin
      sp_q <= sp_q + 1'b1;
    end else if (!pcl_wr && i_op == pfa_pkg::PFA_OP_RET) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  // entries hold no reset value, stale data returned on underflow
  always_ff @(posedge i_ref_clk) begin
    if (i_rst_n && !pcl_wr && (i_op == pfa_pkg::PFA_OP_CALL || i_op == pfa_pkg::PFA_OP_INTR)) begin
      stack_q[sp_q] <= pc_plus1(pc_q);
    end
  end

  //----------------------------------------
  // indirect addressing
  //----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      fsr_q <= 8'h00;
    end else if (i_file_wr && i_file_addr == `PFA_FSR_ADDR) begin
      fsr_q <= i_file_wdata;
    end
  end

  assign eff_addr = {i_indirect_bank_bit, fsr_q};
  assign self_ref = fsr_q[6:0] == `PFA_INDIRECT_DATA_PORT_ADDR;

  always_comb begin
    o_mem_addr = {2'b00, i_file_addr};
    o_mem_wr = i_file_wr && !pcl_wr;
    o_mem_wdata = i_file_wdata;
    o_file_rdata = i_mem_rdata;
    if (is_indirect_data_port) begin
      o_mem_addr = eff_addr;
      o_mem_wr = i_file_wr && !self_ref;
      if (self_ref) begin
        o_file_rdata = `PFA_INDIRECT_DATA_PORT_READ;
      end
    end else if (i_file_addr == `PFA_PCL_ADDR) begin
      o_file_rdata = pc_q[7:0];
    end else if (i_file_addr == `PFA_FSR_ADDR) begin
      o_file_rdata = fsr_q;
    end
  end

  assign o_pc = pc_q;
  assign o_pc_low_byte_reg = pc_q[7:0];
  assign o_indirect_pointer_reg = fsr_q;

  //----------------------------------------
  // checks
  //----------------------------------------
  a_reset_clears_pc: assert property (@(posedge i_ref_clk) !i_rst_n |=> pc_q == 13'h0000)
    else $error("pc not cleared by reset");
  a_pcl_write_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    pcl_wr |=> pc_q == {$past(i_pc_upper_latch[4:0]), $past(i_file_wdata)})
    else $error("low byte write did not load latch bits");
  a_jump_page_sel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_JUMP) |=>
    pc_q == {$past(i_pc_upper_latch[4:3]), $past(i_target)})
    else $error("jump page wrong");
  a_call_ret_pair: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_CALL) ##1 (!pcl_wr && i_op == pfa_pkg::PFA_OP_RET)
    |=> pc_q == $past(pc_q, 2) + 13'h0001)
    else $error("return did not restore call site");
  a_intr_vector: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_INTR) |=> pc_q == 13'h0004 && sp_q == $past(sp_q) + 1'b1)
    else $error("interrupt vector or push wrong");
  a_stack_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_RET && sp_q == '0) |=> sp_q == SPW'(DEPTH - 1))
    else $error("pop did not wrap");
  a_indirect_data_port_self_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (is_indirect_data_port && self_ref) |-> o_file_rdata == 8'h00 && !o_mem_wr)
    else $error("self indirect access leaked");
  a_indirect_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_indirect_data_port |-> o_mem_addr == {i_indirect_bank_bit, fsr_q})
    else $error("effective address wrong");

  // sequencing and stack bookkeeping
  a_next_increment: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_NEXT) |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("counter did not advance");
  a_call_page_sel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_CALL) |=>
    pc_q == {$past(i_pc_upper_latch[4:3]), $past(i_target)})
    else $error("call page wrong");
  a_call_push: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_CALL) |=>
    sp_q == $past(sp_q) + 1'b1 && stack_q[$past(sp_q)] == $past(pc_q) + 13'h0001)
    else $error("call did not push return address");
  a_pop_restore: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_RET) |=> pc_q == $past(stack_q[sp_q - 1'b1]))
    else $error("pop did not restore entry");
  a_pop_pointer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!pcl_wr && i_op == pfa_pkg::PFA_OP_RET) |=> sp_q == $past(sp_q) - 1'b1)
    else $error("pop pointer wrong");
  a_pcl_no_stack: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    pcl_wr |=> sp_q == $past(sp_q))
    else $error("low byte write moved stack");
  a_pcl_no_mem: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    pcl_wr |-> !o_mem_wr)
    else $error("low byte write reached memory");

  // indirect port and direct path
  a_pointer_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_file_wr && i_file_addr == `PFA_FSR_ADDR) |=> fsr_q == $past(fsr_q))
    else $error("pointer changed without write");
  a_direct_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !is_indirect_data_port |-> o_mem_addr == {2'b00, i_file_addr})
    else $error("direct address wrong");
  a_indirect_data_port_pass_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (is_indirect_data_port && !self_ref) |-> o_file_rdata == i_mem_rdata)
    else $error("indirect read data wrong");
  a_indirect_data_port_pass_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (is_indirect_data_port && !self_ref) |-> o_mem_wr == i_file_wr && o_mem_wdata == i_file_wdata)
    else $error("indirect write not passed");

endmodule // pfa_core

// File: pfa_data_mem.sv
// data memory model on the far side of the core's memory port
// assumes one clock, combinational read, write taken at the rising edge
module pfa_data_mem (
  // clock
  input wire logic i_ref_clk,
  // memory port
  input wire logic [8:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [512];
  initial for (int k = 0; k < 512; k++) mem_q[k] = 8'h00;
  assign o_rdata = mem_q[i_addr];
  always @(posedge i_ref_clk) begin
    if (i_wr === 1'b1) mem_q[i_addr] <= i_wdata;
  end
endmodule // pfa_data_mem

// File: pfa_core_bench.sv
// self-checking bench: pfa_core against an integer reference model
// assumes pfa_data_mem as memory; inputs change on the falling edge
module pfa_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic rn = 1'b0;
  pfa_pkg::pfa_op_t i_op = pfa_pkg::PFA_OP_NEXT;
  logic [10:0] i_target = 11'h000;
  logic i_file_wr = 1'b0;
  logic i_indirect_bank_bit = 1'b0;
  logic o_mem_wr;
  logic [6:0] i_file_addr = 7'h00;
  logic [7:0] i_file_wdata = 8'h00, i_pc_upper_latch = 8'h00, i_mem_rdata, o_mem_wdata;
  logic [7:0] o_pc_low_byte_reg, o_indirect_pointer_reg, o_file_rdata, r = 8'h50;
  logic [8:0] o_mem_addr;
  logic [12:0] o_pc;
  int bad_count = 0, checks_done = 0, pc_m = 0, sp_m = 0, ptr_m = 0, ea, hit;
  int stk_m [8];
  int mem_m [512];
  always #5 i_ref_clk = ~i_ref_clk;
  pfa_core pfa_core_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_op(i_op),
    .i_target(i_target), .i_file_wr(i_file_wr), .i_file_addr(i_file_addr),
    .i_file_wdata(i_file_wdata), .i_pc_upper_latch(i_pc_upper_latch),
    .i_indirect_bank_bit(i_indirect_bank_bit), .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(o_mem_addr), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_pc(o_pc),
    .o_pc_low_byte_reg(o_pc_low_byte_reg), .o_indirect_pointer_reg(o_indirect_pointer_reg),
    .o_file_rdata(o_file_rdata));
  pfa_data_mem pfa_data_mem_i (.i_ref_clk(i_ref_clk), .i_addr(o_mem_addr), .i_wr(o_mem_wr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [15:0] got, input int exp);
    checks_done++;
    if (got !== 16'(exp)) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, 16'(exp));
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input logic [4:0] op, input logic wr, input logic [6:0] a);
    @(negedge i_ref_clk);
    chk(o_pc, pc_m);
    chk(o_pc_low_byte_reg, pc_m % 256);
    chk(o_indirect_pointer_reg, ptr_m);
    r = lfsr(r);
    i_rst_n = rn;
    i_op = pfa_pkg::pfa_op_t'(op);
    i_file_wr = wr;
    i_file_addr = a;
    i_file_wdata = (r[2:0] == 3'h0) ? (r & 8'h80) : (r | 8'h20);
    i_pc_upper_latch = lfsr(r);
    i_target = {r, r[7:5]};
    i_indirect_bank_bit = r[6];
    #1;
    ea = int'(r[6]) * 256 + ptr_m;
    hit = (a == 7'h00 && ptr_m % 128 != 0);
    if (!wr) chk(o_file_rdata, a == 2 ? pc_m % 256 : a == 4 ? ptr_m : hit ? mem_m[ea] : 0);
    if (wr) chk(o_mem_wr, a == 7'h00 ? hit : a != 7'h02);
    if (hit) chk(o_mem_addr, ea);
    if (hit && wr) chk(o_mem_wdata, i_file_wdata);
    // memory writes pass through even while the core is held in reset
    if (wr && hit) mem_m[ea] = i_file_wdata;
    if (wr && a != 7'h00 && a != 7'h02) mem_m[a] = i_file_wdata;
    if (!rn) begin
      pc_m = 0;
      sp_m = 0;
      ptr_m = 0;
    end else begin
      if (wr && a == 7'h04) ptr_m = i_file_wdata;
      if (wr && a == 7'h02) pc_m = int'(i_pc_upper_latch[4:0]) * 256 + i_file_wdata;
      else case (op)
        5'h02: pc_m = int'(i_pc_upper_latch[4:3]) * 2048 + i_target;
        5'h04, 5'h10: begin
          stk_m[sp_m] = (pc_m + 1) % 8192;
          sp_m = (sp_m + 1) % 8;
          pc_m = (op == 5'h10) ? 4 : int'(i_pc_upper_latch[4:3]) * 2048 + i_target;
        end
        5'h08: begin
          sp_m = (sp_m + 7) % 8;
          pc_m = stk_m[sp_m];
        end
        default: pc_m = (pc_m + 1) % 8192;
      endcase
    end
  endtask
  initial begin
    for (int k = 0; k < 512; k++) mem_m[k] = 0;
    repeat (2) step(5'h01, 1'b0, 7'h00);
    rn = 1'b1;
    // eighteen pushes wrap the eight entries, ten pops walk past the bottom
    for (int i = 0; i < 28; i++) step(i < 18 ? 5'h04 : 5'h08, 1'b0, 7'h00);
    for (int i = 0; i < 2000; i++) begin
      rn = (i != 1000);
      step(5'h01 << (r % 5), r[1:0] == 2'h0, 7'(2 * (r % 3)));
    end
    step(5'h01, 1'b0, 7'h00);
    end_sim;
  end
  initial begin
    #30000;
    bad_count++;
    end_sim;
  end
endmodule // pfa_core_bench
